// ### src/ltps_pkg.sv
package ltps_pkg;
	localparam int          N_OUT       = 3;
	localparam int          N_WIN       = 3;
	localparam int          CLK_HZ      = 125_000_000;
	localparam int          STEP_MS     = 10;
	localparam int          STEP_CYC    = CLK_HZ / 1000 * STEP_MS;
	localparam int          LEN_MAX_MS  = 10_000;
	localparam int          PPS_LIM_MS  = 990;
	localparam logic [9:0]  LEN_MIN     = 10'h001;
	localparam logic [9:0]  LEN_MAX     = 10'(LEN_MAX_MS / STEP_MS);
	localparam logic [9:0]  PPS_LIM     = 10'(PPS_LIM_MS / STEP_MS);
	localparam int          SEC_PER_MIN = 60;
	localparam int          MIN_PER_HR  = 60;
	localparam int          MIN_PER_DAY = 1440;
	localparam int          SEC_PER_DAY = 86400;
	localparam logic [5:0]  WEEK_REACH  = 6'h06;
	// Word indices; byte address is four times the index
	localparam logic [5:0]  IX_ZONE_STD = 6'h00;
	localparam logic [5:0]  IX_ZONE_SUM = 6'h01;
	localparam logic [5:0]  IX_NAME_STD = 6'h02;
	localparam logic [5:0]  IX_NAME_SUM = 6'h03;
	localparam logic [5:0]  IX_RULE_ON  = 6'h04;
	localparam logic [5:0]  IX_TIME_ON  = 6'h05;
	localparam logic [5:0]  IX_RULE_OFF = 6'h06;
	localparam logic [5:0]  IX_TIME_OFF = 6'h07;
	localparam logic [5:0]  IX_STATUS   = 6'h08;
	localparam logic [5:0]  IX_OUT_BASE = 6'h10;
	localparam int          OUT_STRIDE  = 8;
	localparam int          OF_CFG      = 0;
	localparam int          OF_WIN      = 1;
	localparam int          OF_AUX      = 7;
	localparam int          NUM_WORDS   = 40;
	localparam logic [31:0] M_ZONE      = 32'h0000_0fff;
	localparam logic [31:0] M_NAME      = 32'hffff_ffff;
	localparam logic [31:0] M_RULE      = 32'hffff_0f1f;
	localparam logic [31:0] M_TIME      = 32'h0001_ffff;
	localparam logic [31:0] M_CFG       = 32'h0000_3fff;
	localparam int          RD_DAY_LSB  = 0;
	localparam int          RD_MON_LSB  = 8;
	localparam int          RD_WDAY_LSB = 16;
	localparam int          RD_WILD_BIT = 19;
	localparam int          RD_YEAR_LSB = 20;
	localparam int          CF_MODE_LSB = 0;
	localparam int          CF_POL_BIT  = 3;
	localparam int          CF_LEN_LSB  = 4;
	localparam int          ST_DST_BIT  = 0;
	localparam int          ST_OUT_LSB  = 1;
	localparam int          ST_SOD_LSB  = 4;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic        RST_OUT     = 1'b1;

	typedef enum logic [2:0] {
		OUTPUT_DISABLED_MODE    = 3'h0,
		DAILY_WINDOW_MODE       = 3'h1,
		DAILY_SINGLE_SHOT_MODE  = 3'h2,
		REPEATING_INTERVAL_MODE = 3'h3,
		PER_SECOND_PULSE_MODE   = 3'h4,
		PER_MINUTE_PULSE_MODE   = 3'h5,
		PER_HOUR_PULSE_MODE     = 3'h6
	} ltps_mode_e;
endpackage : ltps_pkg

// ### src/ltps_if.sv
`timescale 1ns/10ps
interface ltps_if;
	logic             sec_tick;
	logic             tick10;
	logic [16:0]      loc_sod;
	logic [5:0]       loc_sec;
	logic [5:0]       loc_min;
	logic [31:0]      cfg;
	logic [5:0][16:0] win;
	logic [16:0]      aux;
	logic             out;

	modport gen (input sec_tick, input tick10, input loc_sod, input loc_sec, input loc_min,
		input cfg, input win, input aux, output out);
	modport ctl (output sec_tick, output tick10, output loc_sod, output loc_sec,
		output loc_min, output cfg, output win, output aux, input out);
endinterface : ltps_if

// ### src/ltps_pulse_gen.sv
`timescale 1ns/10ps
module ltps_pulse_gen
	import ltps_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	ltps_if.gen      pg
);
	typedef struct packed {
		logic        active;
		logic        out;
		logic [9:0]  remain;
	} ltps_pg_s;

	ltps_pg_s   st;
	ltps_pg_s   next_st;
	ltps_mode_e mode;
	logic       pol;
	logic [9:0] len;
	logic       win_act;
	logic       trig;

	function automatic logic in_window(input logic [16:0] t_on, input logic [16:0] t_off,
		input logic [16:0] now);
		if (t_on == t_off)
			return 1'b0;
		else if (t_on < t_off)
			return now >= t_on && now < t_off;
		else
			return now >= t_on || now < t_off;
	endfunction : in_window

	always_comb
	begin
		next_st = st;
		mode = ltps_mode_e'(pg.cfg[CF_MODE_LSB +: 3]);
		pol = pg.cfg[CF_POL_BIT];
		len = pg.cfg[CF_LEN_LSB +: 10];
		if (len < LEN_MIN)
			len = LEN_MIN;
		else if (len > LEN_MAX)
			len = LEN_MAX;
		win_act = 1'b0;
		for (int i = 0; i < N_WIN; i++)
			win_act = win_act | in_window(pg.win[2*i], pg.win[2*i+1], pg.loc_sod);
		case (mode)
			DAILY_SINGLE_SHOT_MODE: trig = pg.sec_tick && pg.loc_sod == pg.aux;
			// Phase from time of day, not a tick count, so jumps stay tied to midnight
			REPEATING_INTERVAL_MODE: trig = pg.sec_tick && pg.aux != 17'h0 &&
				pg.loc_sod % pg.aux == 17'h0;
			PER_SECOND_PULSE_MODE: trig = pg.sec_tick;
			PER_MINUTE_PULSE_MODE: trig = pg.sec_tick && pg.loc_sec == 6'h0;
			PER_HOUR_PULSE_MODE: trig = pg.sec_tick && pg.loc_sec == 6'h0 && pg.loc_min == 6'h0;
			default: trig = 1'b0;
		endcase
		if (trig)
			next_st.remain = len;
		else if (pg.tick10 && st.remain != 10'h0)
			next_st.remain = 10'(st.remain - 10'h1);
		case (mode)
			OUTPUT_DISABLED_MODE: next_st.active = 1'b0;
			DAILY_WINDOW_MODE: next_st.active = win_act;
			PER_SECOND_PULSE_MODE: next_st.active = len > PPS_LIM || next_st.remain != 10'h0;
			default: next_st.active = next_st.remain != 10'h0;
		endcase
		next_st.out = next_st.active ? pol : ~pol;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '{active: 1'b0, out: RST_OUT, remain: 10'h0};
		else
			st <= next_st;
	end

	assign pg.out = st.out;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence fire_s;
		trig ##1 1'b1;
	endsequence

	off_idle_a: assert property (mode == OUTPUT_DISABLED_MODE |=> st.out == $past(~pol))
		else $error("disabled output not idle");
	window_a: assert property (mode == DAILY_WINDOW_MODE |=> st.active == $past(win_act))
		else $error("window output wrong");
	single_a: assert property (mode == DAILY_SINGLE_SHOT_MODE && pg.sec_tick &&
		pg.loc_sod == pg.aux |=> st.active && st.remain == $past(len))
		else $error("single shot missed");
	len_load_a: assert property (fire_s |-> st.remain == $past(len))
		else $error("pulse length not loaded");
	cyclic_a: assert property (mode == REPEATING_INTERVAL_MODE && pg.sec_tick &&
		pg.loc_sod == 17'h0 && pg.aux != 17'h0 |=> st.active)
		else $error("cyclic midnight pulse missed");
	pps_hold_a: assert property ((mode == PER_SECOND_PULSE_MODE && len > PPS_LIM)[*2]
		|-> st.active)
		else $error("long pps not held active");
	polarity_a: assert property (st.out == (st.active ? $past(pol) : !$past(pol)))
		else $error("active level wrong");
endmodule : ltps_pulse_gen

// ### src/ltps_top.sv
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Two zones; local time adds active offset
// - Wildcard year: first matching weekday from date
// - Explicit year: exact date, weekday ignored
// - Identical start and end rules: no changeover
// - Three outputs, each with own mode
// - Window mode: three daily on/off pairs
// - Off before on spans midnight
// - Equal on and off window unused
// - Single shot: one pulse daily at time
// - Pulse length in ten millisecond steps
// - Cyclic pulses aligned to local midnight
// - Per second/minute/hour pulses; long pps held
module ltps_top
	import ltps_pkg::*;
#(
	parameter int STEP_COUNT = STEP_CYC
)
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              utc_tick,
	input  wire logic [11:0]       utc_year,
	input  wire logic [3:0]        utc_month,
	input  wire logic [4:0]        utc_day,
	input  wire logic [2:0]        utc_wday,
	input  wire logic [4:0]        utc_hour,
	input  wire logic [5:0]        utc_min,
	input  wire logic [5:0]        utc_sec,
	output logic [N_OUT-1:0]       programmable_pulse_output,
	output logic                   summer_active
);
	typedef struct packed {
		logic [NUM_WORDS-1:0][31:0] word;
		logic                       dst;
		logic                       wr_pend;
		logic [5:0]                 wr_ix;
		logic [31:0]                rdata;
		logic                       ready;
		logic                       resp;
		logic [20:0]                pre;
		logic                       tick10;
		logic                       sec_tick;
		logic [16:0]                sod;
		logic [5:0]                 sec;
		logic [5:0]                 mins;
		logic [11:0]                yr;
		logic [3:0]                 mon;
		logic [4:0]                 day;
		logic [2:0]                 wday;
	} ltps_top_s;

	ltps_top_s          st;
	ltps_top_s          next_st;
	logic               accept;
	logic               mapped;
	logic [5:0]         ix;
	logic signed [11:0] off_min;
	logic [12:0]        um;
	logic signed [14:0] lm;
	logic [10:0]        lmin;
	logic               on_hit;
	logic               off_hit;
	logic               same;
	logic [N_OUT-1:0]   outs;

	ltps_if pif[N_OUT] ();

	function automatic logic [31:0] wmask(input logic [5:0] a);
		if (a == IX_ZONE_STD || a == IX_ZONE_SUM)
			return M_ZONE;
		else if (a == IX_NAME_STD || a == IX_NAME_SUM)
			return M_NAME;
		else if (a == IX_RULE_ON || a == IX_RULE_OFF)
			return M_RULE;
		else if (a == IX_TIME_ON || a == IX_TIME_OFF)
			return M_TIME;
		else if (a >= IX_OUT_BASE && a < 6'(NUM_WORDS))
			return (a[2:0] == 3'(OF_CFG)) ? M_CFG : M_TIME;
		else
			return 32'h0000_0000;
	endfunction : wmask

	// Wildcard rule matches one of seven days from the set date in the same month
	function automatic logic rule_hit(input logic [31:0] rule, input logic [31:0] at,
		input ltps_top_s s);
		logic [4:0] d;
		logic       date_ok;
		d = rule[RD_DAY_LSB +: 5];
		if (rule[RD_WILD_BIT])
			date_ok = s.mon == rule[RD_MON_LSB +: 4] && s.day >= d &&
				6'(s.day) <= 6'(6'(d) + WEEK_REACH) && s.wday == rule[RD_WDAY_LSB +: 3];
		else
			date_ok = s.yr == rule[RD_YEAR_LSB +: 12] &&
				s.mon == rule[RD_MON_LSB +: 4] && s.day == d;
		return date_ok && s.sod == at[16:0];
	endfunction : rule_hit

	assign ix = haddr[7:2];
	assign accept = hsel && hready && htrans[1];
	assign mapped = haddr[31:8] == 24'h0 && wmask(ix) != 32'h0;

	always_comb
	begin
		next_st = st;
		next_st.ready = 1'b1;
		next_st.resp = 1'b0;
		if (st.wr_pend)
			next_st.word[st.wr_ix] = (st.word[st.wr_ix] & ~wmask(st.wr_ix)) |
				(hwdata & wmask(st.wr_ix));
		next_st.wr_pend = 1'b0;
		// Reads see the word as updated by a write still in its data phase
		if (accept && hwrite)
		begin
			next_st.wr_pend = mapped;
			next_st.wr_ix = ix;
		end
		else if (accept && haddr[31:8] == 24'h0 && ix == IX_STATUS)
		begin
			next_st.rdata = 32'h0;
			next_st.rdata[ST_DST_BIT] = st.dst;
			next_st.rdata[ST_OUT_LSB +: N_OUT] = outs;
			next_st.rdata[ST_SOD_LSB +: 17] = st.sod;
		end
		else if (accept)
			next_st.rdata = mapped ? (next_st.word[ix] & wmask(ix)) : 32'h0;

		// Zone offset in signed minutes, valid within one day either way
		off_min = st.dst ? $signed(st.word[IX_ZONE_SUM][11:0]) :
			$signed(st.word[IX_ZONE_STD][11:0]);
		um = 13'(13'(utc_hour) * 13'(MIN_PER_HR) + 13'(utc_min));
		lm = 15'($signed({2'b00, um}) + 15'(off_min) + 15'(MIN_PER_DAY));
		if (lm >= 15'(2 * MIN_PER_DAY))
			lm = 15'(lm - 15'(2 * MIN_PER_DAY));
		else if (lm >= 15'(MIN_PER_DAY))
			lm = 15'(lm - 15'(MIN_PER_DAY));
		else if (lm < 15'sd0)
			lm = 15'(lm + 15'(MIN_PER_DAY));
		lmin = 11'(lm);
		next_st.sec_tick = utc_tick;
		if (utc_tick)
		begin
			next_st.sod = 17'(17'(lmin) * 17'(SEC_PER_MIN) + 17'(utc_sec));
			next_st.sec = utc_sec;
			next_st.mins = 6'(lmin % 11'(MIN_PER_HR));
			next_st.yr = utc_year;
			next_st.mon = utc_month;
			next_st.day = utc_day;
			next_st.wday = utc_wday;
		end

		// Prescaler restarts with each second so pulse edges align to it
		next_st.tick10 = 1'b0;
		if (st.sec_tick)
			next_st.pre = 21'h0;
		else if (st.pre == 21'(STEP_COUNT - 1))
		begin
			next_st.pre = 21'h0;
			next_st.tick10 = 1'b1;
		end
		else
			next_st.pre = 21'(st.pre + 21'h1);

		on_hit = rule_hit(st.word[IX_RULE_ON], st.word[IX_TIME_ON], st);
		off_hit = rule_hit(st.word[IX_RULE_OFF], st.word[IX_TIME_OFF], st);
		same = (st.word[IX_RULE_ON] & M_RULE) == (st.word[IX_RULE_OFF] & M_RULE) &&
			(st.word[IX_TIME_ON] & M_TIME) == (st.word[IX_TIME_OFF] & M_TIME);
		if (st.sec_tick && !same)
		begin
			if (on_hit)
				next_st.dst = 1'b1;
			else if (off_hit)
				next_st.dst = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign hrdata = st.rdata;
	assign hreadyout = st.ready;
	assign hresp = st.resp;
	assign summer_active = st.dst;
	assign programmable_pulse_output = outs;

	generate
		for (genvar g = 0; g < N_OUT; g++)
		begin : g_out
			localparam int BASE = int'(IX_OUT_BASE) + g * OUT_STRIDE;
			assign pif[g].sec_tick = st.sec_tick;
			assign pif[g].tick10 = st.tick10;
			assign pif[g].loc_sod = st.sod;
			assign pif[g].loc_sec = st.sec;
			assign pif[g].loc_min = st.mins;
			assign pif[g].cfg = st.word[BASE + OF_CFG];
			assign pif[g].aux = st.word[BASE + OF_AUX][16:0];
			for (genvar w = 0; w < 2 * N_WIN; w++)
			begin : g_win
				assign pif[g].win[w] = st.word[BASE + OF_WIN + w][16:0];
			end
			assign outs[g] = pif[g].out;
			ltps_pulse_gen u_gen (
				.hclk    (hclk),
				.hresetn (hresetn),
				.pg      (pif[g])
			);
		end
	endgenerate

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence tick_std_s;
		utc_tick && !st.dst && st.word[IX_ZONE_STD][11:0] == 12'h0;
	endsequence

	loc_range_a: assert property (st.sec_tick |-> st.sod < 17'(SEC_PER_DAY) &&
		st.sec == $past(utc_sec))
		else $error("local time out of range");
	zone_zero_a: assert property (tick_std_s |=> st.sod == 17'($past(utc_hour) * 3600 +
		$past(utc_min) * 60 + $past(utc_sec)))
		else $error("zero offset local time differs from utc");
	dst_start_a: assert property (st.sec_tick && on_hit && !same |=> st.dst)
		else $error("summer time not entered");
	dst_end_a: assert property (st.sec_tick && off_hit && !on_hit && !same |=> !st.dst)
		else $error("summer time not left");
	no_change_a: assert property (same |=> st.dst == $past(st.dst))
		else $error("changeover with identical rules");
	bus_ready_a: assert property (accept && !hwrite ##1 1'b1 |-> hreadyout && !hresp)
		else $error("read not answered at once");
endmodule : ltps_top

// ### testbench/ltps_sink.sv
`timescale 1ns/10ps
// Equipment on one pulse output: counts active runs and keeps the last run length
module ltps_sink
(
	input  wire logic hclk,
	input  wire logic lvl,
	output int        n_pulse,
	output int        last_len
);
	int run;

	initial
	begin
		run = 0;
		n_pulse = 0;
		last_len = 0;
	end

	// Active high is the only polarity the bench measures
	always @(posedge hclk)
	begin
		if (lvl === 1'b1)
			run <= run + 1;
		else
		begin
			if (run > 0)
			begin
				last_len <= run;
				n_pulse <= n_pulse + 1;
			end
			run <= 0;
		end
	end
endmodule : ltps_sink

// ### testbench/ltps_bench.sv
`timescale 1ns/10ps
module ltps_bench;
	import ltps_pkg::*;
	localparam int SC = 4;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, utc_tick, summer_active;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0]  htrans;
	logic [2:0]  hsize, utc_wday, prog_out;
	logic [11:0] utc_year;
	logic [3:0]  utc_month;
	logic [4:0]  utc_day, utc_hour;
	logic [5:0]  utc_min, utc_sec;
	int          np[3], ll[3], b[3];
	int          n_fail, n_compared;

	ltps_top #(.STEP_COUNT(SC)) i_ltps_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.utc_tick(utc_tick), .utc_year(utc_year), .utc_month(utc_month), .utc_day(utc_day),
		.utc_wday(utc_wday), .utc_hour(utc_hour), .utc_min(utc_min), .utc_sec(utc_sec),
		.programmable_pulse_output(prog_out), .summer_active(summer_active));

	for (genvar i = 0; i < 3; i++)
	begin : g_sink
		ltps_sink u_sink (.hclk(hclk), .lvl(prog_out[i]), .n_pulse(np[i]), .last_len(ll[i]));
	end

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One single AHB transfer; waits on hready, bounded
	task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] wd);
		int k;
		hsel <= 1'b1;
		haddr <= {24'h0, ix, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		k = 0;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 100);
		d = hrdata;
		if (k >= 100)
		begin
			chk(0, 1, "bus stall");
			wrap_up();
		end
	endtask : bus

	function automatic logic [5:0] ox(input int n, input int off);
		return 6'(IX_OUT_BASE + OUT_STRIDE * n + off);
	endfunction : ox

	// Tests set both zone offsets to +60 min, so UTC is local minus one hour
	task automatic tick(input int lsod, input int wait_c);
		int u;
		u = lsod - 3600;
		utc_hour <= 5'(u / 3600);
		utc_min <= 6'((u / 60) % 60);
		utc_sec <= 6'(u % 60);
		utc_tick <= 1'b1;
		@(posedge hclk);
		utc_tick <= 1'b0;
		repeat (wait_c) @(posedge hclk);
	endtask : tick

	task automatic day(input int m, input int dd, input int w);
		utc_month <= 4'(m);
		utc_day <= 5'(dd);
		utc_wday <= 3'(w);
	endtask : day

	task automatic snap;
		repeat (4) @(posedge hclk);
		b = np;
	endtask : snap

	initial
	begin
		{hsel, haddr, htrans, hwrite, hwdata, utc_tick} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		utc_year = 12'h7d0;
		{utc_month, utc_day, utc_wday, utc_hour, utc_min, utc_sec} = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'(prog_out), 32'h7, "reset outputs");
		bus(1'b0, ox(0, OF_CFG), 0);
		chk(d, 32'h0, "reset cfg");
		// Offsets still zero: local time equals the UTC time driven, 1:02:02
		tick(7322, 4);
		bus(1'b0, IX_STATUS, 0);
		chk((d >> ST_SOD_LSB) & 32'h1ffff, 32'd3722, "zero offset");
		bus(1'b1, IX_ZONE_STD, 32'hfffff03c);
		bus(1'b0, IX_ZONE_STD, 0);
		chk(d, 32'h3c, "zone mask");
		bus(1'b0, 6'h3f, 0);
		chk(d, 32'h0, "unmapped read");
		chk(32'(hresp), 0, "okay response");
		$display("registers done");

		bus(1'b1, IX_ZONE_SUM, 32'h3c);
		bus(1'b1, ox(0, OF_CFG), 32'h2c);
		bus(1'b1, ox(1, OF_CFG), 32'h2a);
		bus(1'b1, ox(1, OF_AUX), 32'd39600);
		bus(1'b1, ox(2, OF_CFG), 32'h2b);
		bus(1'b1, ox(2, OF_AUX), 32'd2);
		snap();
		tick(39600, 16);
		bus(1'b0, IX_STATUS, 0);
		chk((d >> ST_SOD_LSB) & 32'h1ffff, 32'd39600, "local time");
		tick(39601, 16);
		tick(39602, 16);
		chk(np[0] - b[0], 3, "pps count");
		chk(32'(ll[0] == 2 * SC || ll[0] == 2 * SC + 1), 1, "pulse length");
		chk(np[1] - b[1], 1, "single shot count");
		chk(np[2] - b[2], 2, "cyclic count");
		bus(1'b1, ox(1, OF_CFG), 32'h2d);
		bus(1'b1, ox(2, OF_CFG), 32'h2e);
		snap();
		tick(39660, 16);
		tick(39661, 16);
		tick(43200, 16);
		chk(np[1] - b[1], 2, "ppm count");
		chk(np[2] - b[2], 1, "pph count");
		$display("pulse modes done");

		bus(1'b1, ox(2, OF_CFG), 32'h09);
		bus(1'b1, ox(2, OF_WIN), 32'd86000);
		bus(1'b1, ox(2, OF_WIN + 1), 32'd7200);
		bus(1'b1, ox(2, OF_WIN + 2), 32'd7250);
		bus(1'b1, ox(2, OF_WIN + 3), 32'd7250);
		bus(1'b1, ox(2, OF_WIN + 4), 32'd40000);
		bus(1'b1, ox(2, OF_WIN + 5), 32'd41000);
		tick(86000, 8);
		chk(32'(prog_out[2]), 1, "window on");
		tick(5000, 8);
		chk(32'(prog_out[2]), 1, "past midnight");
		tick(7200, 8);
		chk(32'(prog_out[2]), 0, "window off");
		tick(7250, 8);
		chk(32'(prog_out[2]), 0, "unused window");
		tick(40000, 8);
		chk(32'(prog_out[2]), 1, "second window on");
		tick(41000, 8);
		chk(32'(prog_out[2]), 0, "second window off");
		bus(1'b1, ox(0, OF_CFG), 32'h08);
		tick(41001, 8);
		chk(32'(prog_out[0]), 0, "disabled inactive");
		$display("window modes done");

		// Start rule carries a weekday that must be ignored
		bus(1'b1, IX_RULE_ON, 32'h7d05031a);
		bus(1'b1, IX_TIME_ON, 32'd7200);
		bus(1'b1, IX_RULE_OFF, 32'h00080a19);
		bus(1'b1, IX_TIME_OFF, 32'd7200);
		day(3, 25, 6);
		tick(7200, 4);
		tick(7201, 8);
		chk(32'(summer_active), 0, "day before start");
		day(3, 26, 0);
		tick(7200, 4);
		tick(7201, 8);
		chk(32'(summer_active), 1, "exact start date");
		bus(1'b0, IX_STATUS, 0);
		chk(d & 32'h1, 1, "status summer");
		day(10, 26, 4);
		tick(7200, 4);
		tick(7201, 8);
		chk(32'(summer_active), 1, "weekday mismatch");
		day(10, 29, 0);
		tick(7200, 4);
		tick(7201, 8);
		chk(32'(summer_active), 0, "first sunday end");
		bus(1'b1, IX_RULE_OFF, 32'h7d05031a);
		day(3, 26, 0);
		tick(7200, 4);
		tick(7201, 8);
		chk(32'(summer_active), 0, "identical rules");
		$display("changeover done");

		bus(1'b1, ox(0, OF_CFG), 32'h64c);
		tick(50000, 450);
		chk(32'(prog_out[0]), 1, "long pps held");
		$display("long pps done");
		wrap_up();
	end
endmodule : ltps_bench
